// ===== src/ais_sequencer.sv
/*
  Acquisition sequencer: channel scan, sampling clock selection, start
  condition, sample buffer as FIFO or ring, repeat control and status.
  Assumes an ADC front end on clk that answers each adc_req with one
  adc_done pulse, and that DEPTH is a power of two.
*/
`timescale 1ns/10ps
module ais_sequencer
  import ais_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic diff_jumper_pin,
  input wire logic chan_by_count,
  input wire logic [CH_CNT_W-1:0] chan_value,
  input wire logic ext_clk_sel,
  input wire logic [CNT_W-1:0] int_period,
  input wire logic ext_clk_pin,
  input wire logic [1:0] start_src,
  input wire logic [CH_W-1:0] cmp_chan,
  input wire logic [CODE_W-1:0] cmp_level,
  input wire logic [1:0] cmp_dir,
  input wire logic trig_pin,
  input wire logic trig_rising,
  input wire logic ring_mode,
  input wire logic [AW:0] fill_thresh,
  input wire logic [AW-1:0] area_lo,
  input wire logic [AW-1:0] area_hi,
  input wire logic [CNT_W-1:0] rep_total,
  input wire logic [CNT_W-1:0] samples_per_rep,
  input wire logic start_cmd,
  input wire logic abort_cmd,
  input wire logic status_clear,
  output logic adc_req,
  output logic [CH_W-1:0] adc_chan,
  input wire logic adc_done,
  input wire logic [CODE_W-1:0] adc_data,
  input wire logic rd_req,
  input wire logic [AW-1:0] rd_back,
  output logic [CODE_W-1:0] rd_data,
  output logic rd_valid,
  output logic busy,
  output logic waiting,
  output logic fill_flag,
  output logic full_flag,
  output logic overflow,
  output logic area_flag,
  output logic clk_error,
  output logic diff_mode,
  output logic [AW:0] level,
  output logic [CNT_W-1:0] rep_cur,
  output logic ev_start_met,
  output logic ev_rep_end,
  output logic ev_op_end,
  output logic ev_fill,
  output logic ev_overflow,
  output logic ev_area,
  output logic ev_clk_error
);

  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // pins

  logic jumper_lvl;
  logic ext_clk_rise;
  logic trig_rise;
  logic trig_fall;

  ais_pin_sync u_jumper_sync (
    .clk(clk), .rst(rst), .pin(diff_jumper_pin),
    .level(jumper_lvl), .rise(), .fall()
  );

  ais_pin_sync u_ext_clk_sync (
    .clk(clk), .rst(rst), .pin(ext_clk_pin),
    .level(), .rise(ext_clk_rise), .fall()
  );

  ais_pin_sync u_trig_sync (
    .clk(clk), .rst(rst), .pin(trig_pin),
    .level(), .rise(trig_rise), .fall(trig_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers

  ais_state_type state_reg;
  ais_state_type state_next;
  logic [CNT_W-1:0] div_reg;
  logic scan_reg;
  logic store_reg;
  logic [CH_W-1:0] ch_reg;
  logic prev_above_reg;
  logic prev_valid_reg;
  logic [CNT_W-1:0] samp_reg;
  logic [CNT_W-1:0] rep_reg;
  logic [CODE_W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;

  ////////////////////////////////////////////////////////////////////////////
  // channel selection and sampling tick

  // the range is fixed, so no range setting exists on this block
  wire [CH_CNT_W-1:0] nch_avail = jumper_lvl ? NCH_DIFF : NCH_SINGLE;
  wire [CH_CNT_W-1:0] cnt_clamp = (chan_value == '0) ? CH_CNT_W'(1) :
                                  (chan_value > nch_avail) ? nch_avail : chan_value;
  wire [CH_CNT_W-1:0] one_clamp = (chan_value >= nch_avail) ? (nch_avail - CH_CNT_W'(1)) : chan_value;
  wire [CH_W-1:0] first_ch = chan_by_count ? '0 : one_clamp[CH_W-1:0];
  wire [CH_CNT_W-1:0] last_wide = chan_by_count ? (cnt_clamp - CH_CNT_W'(1)) : one_clamp;
  wire [CH_W-1:0] last_ch = last_wide[CH_W-1:0];

  // a period of 0 or 1 ticks every cycle instead of wrapping to the longest period
  wire int_tick = (int_period <= CNT_ONE) | (div_reg >= int_period - CNT_ONE);
  wire tick = ext_clk_sel ? ext_clk_rise : int_tick;
  wire active = (state_reg != AIS_IDLE);
  wire scan_start = active & tick & ~scan_reg;
  // a tick that lands inside a running scan means the period is too short
  wire clk_err = active & tick & scan_reg;

  ////////////////////////////////////////////////////////////////////////////
  // conversion results and comparison

  wire done_ok = adc_done & scan_reg;
  wire scan_last = done_ok & (ch_reg == last_ch);
  wire in_run = (state_reg == AIS_RUN);
  wire wr_en = done_ok & store_reg & in_run;
  wire fifo_full = (count_reg == DEPTH_CNT);
  wire ovf_hit = wr_en & fifo_full & ~ring_mode;
  wire wr_do = wr_en & ~ovf_hit;
  wire rd_do = rd_req & ~ring_mode & (count_reg != '0);

  wire cmp_sample = done_ok & (ch_reg == cmp_chan);
  wire cur_above = (adc_data >= cmp_level);
  wire cross_up = prev_valid_reg & ~prev_above_reg & cur_above;
  wire cross_dn = prev_valid_reg & prev_above_reg & ~cur_above;
  wire cmp_match = cmp_sample & ((cmp_dir[DIR_RISE_BIT] & cross_up) |
                                 (cmp_dir[DIR_FALL_BIT] & cross_dn));
  wire trig_hit = trig_rising ? trig_rise : trig_fall;
  wire start_met = (state_reg == AIS_WAIT) &
                   (((start_src == START_EXT) & trig_hit) |
                    ((start_src == START_CMP) & cmp_match));

  wire event_end = scan_last & store_reg & in_run;
  wire [CNT_W-1:0] samp_inc = samp_reg + CNT_ONE;
  wire [CNT_W-1:0] rep_inc = rep_reg + CNT_ONE;
  wire rep_end = event_end & (samp_inc == samples_per_rep);
  wire last_rep = (rep_total != REP_INFINITE) & (rep_inc == rep_total);
  wire [CNT_W-1:0] rep_next = !active ? (start_cmd ? CNT_RESET : rep_reg) : (rep_end ? rep_inc : rep_reg);
  wire [AW-1:0] ring_idx = wr_ptr_reg - rd_back - AW'(1);
  wire in_area = (wr_ptr_reg >= area_lo) & (wr_ptr_reg <= area_hi);
  wire area_set = wr_do & ring_mode & in_area;

  ////////////////////////////////////////////////////////////////////////////
  // state machine

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      AIS_IDLE: begin
        if (start_cmd) begin
          state_next = (start_src == START_SW) ? AIS_RUN : AIS_WAIT;
        end
      end
      AIS_WAIT: begin
        if (abort_cmd | clk_err) begin
          state_next = AIS_IDLE;
        end else if (start_met) begin
          state_next = AIS_RUN;
        end
      end
      AIS_RUN: begin
        if (abort_cmd | clk_err | ovf_hit) begin
          state_next = AIS_IDLE;
        end else if (rep_end) begin
          if (last_rep) begin
            state_next = AIS_IDLE;
          end else begin
            state_next = (start_src == START_SW) ? AIS_RUN : AIS_WAIT;
          end
        end
      end
      default: state_next = AIS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= AIS_IDLE;
      div_reg <= CNT_RESET;
    end else begin
      state_reg <= state_next;
      div_reg <= int_tick ? CNT_RESET : div_reg + CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel scan

  always_ff @(posedge clk) begin
    if (rst) begin
      scan_reg <= 1'b0;
      store_reg <= 1'b0;
      ch_reg <= '0;
      adc_req <= 1'b0;
      adc_chan <= '0;
    end else begin
      adc_req <= 1'b0;
      if (!active) begin
        scan_reg <= 1'b0;
      end else if (scan_start) begin
        scan_reg <= 1'b1;
        // storage is decided per event so a start mid-scan never stores a partial event
        store_reg <= in_run;
        ch_reg <= first_ch;
        adc_chan <= first_ch;
        adc_req <= 1'b1;
      end else if (scan_last) begin
        scan_reg <= 1'b0;
      end else if (done_ok) begin
        ch_reg <= ch_reg + CH_W'(1);
        adc_chan <= ch_reg + CH_W'(1);
        adc_req <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_above_reg <= 1'b0;
      prev_valid_reg <= 1'b0;
    end else if (state_next != AIS_WAIT) begin
      prev_valid_reg <= 1'b0;
    end else if (cmp_sample) begin
      prev_above_reg <= cur_above;
      prev_valid_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // repetition counting

  always_ff @(posedge clk) begin
    if (rst) begin
      samp_reg <= CNT_RESET;
      rep_reg <= CNT_RESET;
    end else if (!active) begin
      samp_reg <= CNT_RESET;
      if (start_cmd) begin
        rep_reg <= CNT_RESET;
      end
    end else if (rep_end) begin
      samp_reg <= CNT_RESET;
      rep_reg <= rep_inc;
    end else if (event_end) begin
      samp_reg <= samp_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample buffer

  always_comb begin
    count_next = count_reg;
    if (ring_mode) begin
      if (wr_do && !fifo_full) begin
        count_next = count_reg + (AW+1)'(1);
      end
    end else if (wr_do && !rd_do) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (rd_do && !wr_do) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (wr_do) begin
      mem[wr_ptr_reg] <= adc_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      count_reg <= count_next;
      if (wr_do) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (rd_do) begin
        rd_data <= mem[rd_ptr_reg];
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
        rd_valid <= 1'b1;
      end else if (rd_req && ring_mode && count_reg != '0) begin
        // ring data stays in place and is addressed back from the write point
        rd_data <= mem[ring_idx];
        rd_valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and events

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      waiting <= 1'b0;
      fill_flag <= 1'b0;
      full_flag <= 1'b0;
      overflow <= 1'b0;
      area_flag <= 1'b0;
      clk_error <= 1'b0;
      diff_mode <= 1'b0;
      level <= '0;
      rep_cur <= CNT_RESET;
    end else begin
      busy <= (state_next != AIS_IDLE);
      waiting <= (state_next == AIS_WAIT);
      fill_flag <= ~ring_mode & (count_next >= fill_thresh);
      full_flag <= (count_next == DEPTH_CNT);
      // sticky flags: a new event in the clearing cycle wins
      overflow <= (wr_en & fifo_full) | (overflow & ~status_clear);
      area_flag <= area_set | (area_flag & ~status_clear);
      clk_error <= clk_err | (clk_error & ~status_clear);
      diff_mode <= jumper_lvl;
      level <= count_next;
      rep_cur <= rep_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_start_met <= 1'b0;
      ev_rep_end <= 1'b0;
      ev_op_end <= 1'b0;
      ev_fill <= 1'b0;
      ev_overflow <= 1'b0;
      ev_area <= 1'b0;
      ev_clk_error <= 1'b0;
    end else begin
      ev_start_met <= start_met & ~abort_cmd & ~clk_err;
      ev_rep_end <= rep_end & in_run & ~abort_cmd & ~clk_err & ~ovf_hit;
      ev_op_end <= active & (state_next == AIS_IDLE);
      ev_fill <= ~ring_mode & (count_next >= fill_thresh) & ~fill_flag;
      ev_overflow <= wr_en & fifo_full;
      ev_area <= area_set & ~area_flag;
      ev_clk_error <= clk_err;
    end
  end

endmodule : ais_sequencer

// ===== src/ais_pkg.sv
/*
  Shared constants and types of the acquisition sequencer: state codes,
  start-source and comparison-direction encodings, widths and reset values.
  Assumes nothing of its surroundings.
*/
package ais_pkg;

  // clock of the block
  localparam int CLK_PERIOD_NS = 40;

  // sample word and channel addressing
  localparam int CODE_W = 16;
  localparam int CH_W = 6;
  localparam int CH_CNT_W = CH_W + 1;
  localparam logic [CH_CNT_W-1:0] NCH_SINGLE = 7'h40;
  localparam logic [CH_CNT_W-1:0] NCH_DIFF = 7'h20;

  // repeat and per-repetition counts
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] REP_INFINITE = 16'h0000;

  // start sources
  localparam logic [1:0] START_SW = 2'h0;
  localparam logic [1:0] START_CMP = 2'h1;
  localparam logic [1:0] START_EXT = 2'h2;

  // comparison direction bit positions
  localparam int DIR_RISE_BIT = 0;
  localparam int DIR_FALL_BIT = 1;

  // sequencer states, gray along idle -> wait -> run
  typedef enum logic [1:0] {
    AIS_IDLE = 2'h0,
    AIS_WAIT = 2'h1,
    AIS_RUN = 2'h3
  } ais_state_type;

endpackage : ais_pkg

// ===== src/ais_pin_sync.sv
/*
  Two-stage synchroniser for one asynchronous pin with edge detection.
  Assumes the pin is a plain level from outside the clock domain.
*/
`timescale 1ns/10ps
module ais_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edges are taken between the second and third stages only
  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;

endmodule : ais_pin_sync

// ===== dv/ais_props.sv
/*
  Checker of the acquisition sequencer's ports.
  Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/10ps
module ais_props
  import ais_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start_cmd,
  input wire logic [1:0] start_src,
  input wire logic chan_by_count,
  input wire logic ring_mode,
  input wire logic rd_req,
  input wire logic busy,
  input wire logic waiting,
  input wire logic adc_req,
  input wire logic [CH_W-1:0] adc_chan,
  input wire logic full_flag,
  input wire logic [AW:0] level,
  input wire logic rd_valid,
  input wire logic [CNT_W-1:0] rep_cur,
  input wire logic ev_op_end,
  input wire logic ev_start_met,
  input wire logic ev_overflow,
  input wire logic ev_rep_end,
  input wire logic fill_flag,
  input wire logic ev_fill,
  input wire logic area_flag,
  input wire logic ev_area,
  input wire logic ev_clk_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire idle_go = start_cmd && !busy;
  ////////////////////////////////////////
  a_sw_run: assert property (idle_go && start_src == START_SW |=> busy && !waiting)
    else $error("software start did not run at once");
  a_wait_start: assert property (idle_go && start_src != START_SW |=> busy && waiting)
    else $error("start did not enter waiting");
  a_chan_up: assert property (adc_req && chan_by_count && adc_chan != '0 |-> adc_chan == $past(adc_chan) + 1'b1)
    else $error("channel scan not ascending");
  a_full_lvl: assert property (full_flag |-> level == DEPTH)
    else $error("full flag without full level");
  a_rd_ans: assert property (rd_req && level != '0 |=> rd_valid)
    else $error("read not answered");
  a_rd_cause: assert property (rd_valid |-> $past(rd_req))
    else $error("read data without request");
  a_end_pulse: assert property ($fell(busy) |-> ev_op_end)
    else $error("operation end not notified");
  a_start_ev: assert property (ev_start_met |-> busy && !waiting)
    else $error("start met while still waiting");
  a_fifo_stop: assert property (ev_overflow && !ring_mode |-> ##[0:1] !busy)
    else $error("fifo overflow did not stop");
  a_ring_go: assert property (ev_overflow && ring_mode |-> busy)
    else $error("ring overflow stopped");
  a_rep_step: assert property (ev_rep_end |-> rep_cur == $past(rep_cur) + 1'b1)
    else $error("repeat count not stepped");
  a_fill_ev: assert property (ev_fill |-> fill_flag && !$past(fill_flag))
    else $error("fill event without new fill status");
  a_area_ev: assert property (ev_area |-> area_flag && ring_mode)
    else $error("area event without area status");
  a_clk_stop: assert property (ev_clk_error |-> !busy && ev_op_end)
    else $error("clock error did not stop");
  c_start: cover property ($fell(waiting) && busy);
  c_ring: cover property (ev_overflow && ring_mode);
  c_rep: cover property (ev_rep_end && busy);
endmodule : ais_props

// ===== dv/ais_adc_model.sv
/*
  Behavioural converter front end: answers each request with base plus channel.
  Assumes one request outstanding at a time, on the sequencer's clock.
*/
`timescale 1ns/10ps
module ais_adc_model
  import ais_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic adc_req,
  input wire logic [CH_W-1:0] adc_chan,
  input wire logic [CODE_W-1:0] base,
  output logic adc_done,
  output logic [CODE_W-1:0] adc_data
);
  logic [1:0] pend;
  logic [CODE_W-1:0] val;
  always_ff @(posedge clk) begin
    pend <= rst ? 2'h0 : {pend[0], adc_req};
    if (adc_req) val <= base + adc_chan;
  end
  assign adc_done = slow ? pend[1] : pend[0];
  // outside the answer cycle the bus shows garbage, not the old word
  assign adc_data = adc_done ? val : ~val;
endmodule : ais_adc_model

// ===== dv/tb.sv
/*
  Self-checking bench of the acquisition sequencer with a converter model.
  Assumes DEPTH 16 and a sample tick every 16 clocks.
*/
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module tb;
  import ais_pkg::*;
  localparam int AW = 4;
  logic clk = 0, rst = 1, dj = 0, cbc = 1, ecs = 0, ecp = 0, tp = 0, tr = 1, rm = 0;
  logic sc = 0, ab = 0, scl = 0, rdq = 0, slow = 0;
  logic [6:0] cv = 7'h01;
  logic [15:0] ip = 16'h0010, cl = 16'h8000, rt = 16'h0001, spr = 16'h0001;
  logic [15:0] base = 16'h1000, rd_data, rep_cur, adc_data;
  logic [1:0] ss = 2'h0, cd = 2'h1;
  logic [5:0] adc_chan, cch = 6'h01;
  logic [4:0] ft = 5'h08, level;
  logic [3:0] alo = 4'h2, ahi = 4'h3, rb = 4'h0;
  logic adc_req, adc_done, rd_valid, busy, waiting, fill_flag, full_flag, overflow, area_flag, diff_mode;
  logic clk_error;
  int error_cnt = 0, n_tests = 0, cyc = 0, i, k;
  always #20 clk = ~clk;
  ais_sequencer #(.DEPTH(16)) u_dut (.clk(clk), .rst(rst), .diff_jumper_pin(dj), .chan_by_count(cbc),
    .chan_value(cv), .ext_clk_sel(ecs), .int_period(ip), .ext_clk_pin(ecp), .start_src(ss),
    .cmp_chan(cch), .cmp_level(cl), .cmp_dir(cd), .trig_pin(tp), .trig_rising(tr), .ring_mode(rm),
    .fill_thresh(ft), .area_lo(alo), .area_hi(ahi), .rep_total(rt), .samples_per_rep(spr),
    .start_cmd(sc), .abort_cmd(ab), .status_clear(scl), .adc_req(adc_req), .adc_chan(adc_chan),
    .adc_done(adc_done), .adc_data(adc_data), .rd_req(rdq), .rd_back(rb), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy), .waiting(waiting), .fill_flag(fill_flag), .full_flag(full_flag),
    .overflow(overflow), .area_flag(area_flag), .clk_error(clk_error), .diff_mode(diff_mode), .level(level),
    .rep_cur(rep_cur), .ev_start_met(), .ev_rep_end(), .ev_op_end(), .ev_fill(), .ev_overflow(),
    .ev_area(), .ev_clk_error());
  ais_adc_model u_adc (.clk(clk), .rst(rst), .slow(slow), .adc_req(adc_req), .adc_chan(adc_chan),
    .base(base), .adc_done(adc_done), .adc_data(adc_data));
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic go(input logic [1:0] src);
    @(negedge clk) ss = src;
    sc = 1;
    @(negedge clk) sc = 0;
  endtask : go
  task automatic cfg(input logic [6:0] v, input logic [15:0] reps, input logic [15:0] per);
    @(negedge clk) cv = v;
    rt = reps;
    spr = per;
  endtask : cfg
  task automatic wait_idle();
    for (int j = 0; j < 3000 && busy !== 1'b0; j++) @(negedge clk);
    `CHK("busy", 1'b0, busy)
  endtask : wait_idle
  task automatic rd(input logic [15:0] exp);
    @(negedge clk) rdq = 1;
    @(negedge clk) rdq = 0;
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", exp, rd_data)
  endtask : rd
  ////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    cfg(7'h03, 16'h0001, 16'h0002);
    go(START_SW);
    `CHK("waiting", 1'b0, waiting)
    wait_idle();
    `CHK("level", 5'h06, level)
    `CHK("rep_cur", 16'h0001, rep_cur)
    for (i = 0; i < 6; i++) rd(base + i % 3);
    @(negedge clk) rdq = 1;
    @(negedge clk) rdq = 0;
    `CHK("rd_empty", 1'b0, rd_valid)
    $display("test scan done");
    slow = 1;
    cfg(7'h02, 16'h0002, 16'h0001);
    go(START_SW);
    wait_idle();
    `CHK("rep_cur", 16'h0002, rep_cur)
    for (i = 0; i < 4; i++) rd(base + i % 2);
    slow = 0;
    $display("test repeat done");
    // two channels scanned, the comparison watches channel 1 only
    cfg(7'h02, 16'h0001, 16'h0002);
    for (k = 0; k < 3; k++) begin
      cd = 2'(k + 1);
      base = (k == 1) ? 16'h9000 : 16'h1000;
      go(START_CMP);
      repeat (60) @(negedge clk);
      `CHK("waiting", 1'b1, waiting)
      `CHK("level", 5'h00, level)
      base = base ^ 16'h8000;
      wait_idle();
      `CHK("level", 5'h04, level)
      rd(base);
      rd(base + 16'h0001);
      rd(base);
      rd(base + 16'h0001);
    end
    base = 16'h1000;
    cfg(7'h01, 16'h0001, 16'h0002);
    $display("test compare done");
    for (k = 0; k < 2; k++) begin
      tr = k[0];
      tp = !k[0];
      repeat (4) @(negedge clk);
      go(START_EXT);
      repeat (40) @(negedge clk);
      `CHK("waiting", 1'b1, waiting)
      tp = k[0];
      wait_idle();
      `CHK("level", 5'h02, level)
      rd(base);
      rd(base);
    end
    $display("test trigger done");
    ecs = 1;
    cfg(7'h01, 16'h0001, 16'h0003);
    go(START_SW);
    repeat (40) @(negedge clk);
    `CHK("level", 5'h00, level)
    for (i = 0; i < 3; i++) begin
      ecp = 1;
      repeat (15) @(negedge clk);
      ecp = 0;
      repeat (15) @(negedge clk);
    end
    wait_idle();
    `CHK("level", 5'h03, level)
    for (i = 0; i < 3; i++) rd(base);
    ecs = 0;
    $display("test ext clock done");
    dj = 1;
    cbc = 0;
    cfg(7'h28, 16'h0001, 16'h0001);
    repeat (5) @(negedge clk);
    `CHK("diff_mode", 1'b1, diff_mode)
    go(START_SW);
    wait_idle();
    rd(base + 16'h001F);
    cbc = 1;
    $display("test diff done");
    // a tick every clock lands inside the open scan
    ip = 16'h0001;
    go(START_SW);
    wait_idle();
    `CHK("clk_error", 1'b1, clk_error)
    ip = 16'h0010;
    @(negedge clk) scl = 1;
    @(negedge clk) scl = 0;
    `CHK("clk_error", 1'b0, clk_error)
    `CHK("level", 5'h00, level)
    $display("test clock error done");
    // continuous run: only the full buffer may stop it
    cfg(7'h01, 16'h0000, 16'h0000);
    go(START_SW);
    wait_idle();
    `CHK("overflow", 1'b1, overflow)
    `CHK("full_flag", 1'b1, full_flag)
    `CHK("fill_flag", 1'b1, fill_flag)
    rd(base);
    `CHK("full_flag", 1'b0, full_flag)
    @(negedge clk) scl = 1;
    @(negedge clk) scl = 0;
    `CHK("overflow", 1'b0, overflow)
    for (i = 0; i < 15; i++) rd(base);
    $display("test fifo done");
    rm = 1;
    go(START_SW);
    repeat (300) @(negedge clk);
    base = 16'h3000;
    repeat (200) @(negedge clk);
    `CHK("busy", 1'b1, busy)
    `CHK("overflow", 1'b1, overflow)
    `CHK("area_flag", 1'b1, area_flag)
    @(negedge clk) ab = 1;
    @(negedge clk) ab = 0;
    `CHK("busy", 1'b0, busy)
    rd(16'h3000);
    rb = 4'hF;
    rd(16'h1000);
    `CHK("level", 5'h10, level)
    $display("test ring done");
    print_verdict();
  end
endmodule : tb
bind ais_sequencer ais_props #(.DEPTH(DEPTH), .AW(AW)) u_props (.clk(clk), .rst(rst), .start_cmd(start_cmd),
  .start_src(start_src), .chan_by_count(chan_by_count), .ring_mode(ring_mode), .rd_req(rd_req), .busy(busy),
  .waiting(waiting), .adc_req(adc_req), .adc_chan(adc_chan), .full_flag(full_flag), .level(level),
  .rd_valid(rd_valid), .rep_cur(rep_cur), .ev_op_end(ev_op_end), .ev_start_met(ev_start_met),
  .ev_overflow(ev_overflow), .ev_rep_end(ev_rep_end), .fill_flag(fill_flag), .ev_fill(ev_fill),
  .area_flag(area_flag), .ev_area(ev_area), .ev_clk_error(ev_clk_error));
